// ### fpmc_consts.svh
/*
  Opcodes, status bit positions and timing figures of the flash power-mode
  and page-size configuration block.
  Assumes a 125 MHz system clock; times are maximum figures in ns.
*/
`ifndef FPMC_CONSTS_SVH
`define FPMC_CONSTS_SVH

// opcodes
`define FPMC_OP_DEEP      8'hB9
`define FPMC_OP_RESUME    8'hAB
`define FPMC_OP_ULTRA     8'h79
`define FPMC_CFG_B0       8'h3D
`define FPMC_CFG_B1       8'h2A
`define FPMC_CFG_B2       8'h80
`define FPMC_CFG_B3_256   8'hA6
`define FPMC_CFG_B3_264   8'hA7
`define FPMC_CFG_LEN      3'h4

// status bit positions
`define FPMC_ST_READY     7
`define FPMC_ST1_COMPARE  6
`define FPMC_ST1_DENS_LO  2
`define FPMC_ST1_PROTECT  1
`define FPMC_ST1_PAGE256  0
`define FPMC_ST2_FAIL     5

// reset values
`define FPMC_PAGE256_RST  1'b1
`define FPMC_PIN_RST      3'h4

// times in ns, clock period in ns
`define FPMC_CLK_NS       8
`define FPMC_T_DEEP_IN    3000
`define FPMC_T_DEEP_OUT   7000
`define FPMC_T_ULTRA_IN   3000
`define FPMC_T_ULTRA_OUT  100000
`define FPMC_T_CFG_PROG   3000000

// longest time rounds down, never below one cycle
`define FPMC_CYC(ns) (((ns) / `FPMC_CLK_NS) < 1 ? 1 : ((ns) / `FPMC_CLK_NS))

`endif

// ### fpmc_pkg.sv
/*
  Types of the flash power-mode and page-size configuration block.
  Assumes nothing of its surroundings.
*/
package fpmc_pkg;

  typedef enum logic [2:0]
  {
    PW_STANDBY,
    PW_CONFIG,
    PW_DEEP_ENTER,
    PW_DEEP,
    PW_DEEP_RESUME,
    PW_ULTRA_ENTER,
    PW_ULTRA,
    PW_ULTRA_EXIT
  } fpmc_state_t;

endpackage

// ### fpmc_sync.sv
/*
  Two-flop synchroniser, one chain per bit.
  Assumes inputs asynchronous to clk; RST_VAL is the idle level of each bit.
*/
`timescale 1ns/10ps

module fpmc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : chain
      logic meta;
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          meta <= RST_VAL[i];
          q[i] <= RST_VAL[i];
        end
        else
        begin
          meta <= d[i];
          q[i] <= meta;
        end
      end
    end
  endgenerate

endmodule // fpmc_sync

// ### fpmc_top.sv
/*
  Power-mode and page-size configuration command handling of a serial flash,
  device side of the serial link: frames decoded on cs_n / sck / si.
  Assumes SPI mode 0 or 3 (si sampled on sck rise), sck well below clk / 4,
  and an array engine on clk that reports its own busy and results.
*/
`timescale 1ns/10ps
`include "fpmc_consts.svh"

module fpmc_top
  import fpmc_pkg::*;
#(
  parameter int         DEEP_ENTRY_CYC  = `FPMC_CYC(`FPMC_T_DEEP_IN),
  parameter int         DEEP_RESUME_CYC = `FPMC_CYC(`FPMC_T_DEEP_OUT),
  parameter int         ULTRA_ENTRY_CYC = `FPMC_CYC(`FPMC_T_ULTRA_IN),
  parameter int         ULTRA_EXIT_CYC  = `FPMC_CYC(`FPMC_T_ULTRA_OUT),
  parameter int         CONFIG_CYC      = `FPMC_CYC(`FPMC_T_CFG_PROG),
  parameter int         TW              = 20,
  // density code; value arbitrary
  parameter logic [3:0] DENSITY_CODE    = 4'hA
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // serial link pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  // array engine
  input  wire logic       array_busy,
  input  wire logic       op_done,
  input  wire logic       op_fail,
  input  wire logic       op_abort,
  input  wire logic       compare_result,
  input  wire logic       protect_on,
  // nonvolatile page-size cell
  input  wire logic       nv_page_256,
  output logic            nv_store,
  output logic            nv_store_value,
  // mode and status
  output logic            standby,
  output logic            deep_sleep,
  output logic            ultra_sleep,
  output logic            ready,
  output logic            cmd_enable,
  output logic            status_enable,
  output logic            buffer_lost,
  output logic            program_fail_flag,
  output logic            page_256,
  output logic [7:0]      status_byte1,
  output logic [7:0]      status_byte2
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks

  if (DEEP_ENTRY_CYC < 1 || DEEP_RESUME_CYC < 1 || ULTRA_ENTRY_CYC < 1 ||
      ULTRA_EXIT_CYC < 1 || CONFIG_CYC < 1)
  begin : bad_count
    $error("fpmc_top: every timing count must be at least one cycle");
  end
  if (DEEP_ENTRY_CYC >= 2**TW || DEEP_RESUME_CYC >= 2**TW ||
      ULTRA_ENTRY_CYC >= 2**TW || ULTRA_EXIT_CYC >= 2**TW ||
      CONFIG_CYC >= 2**TW)
  begin : bad_width
    $error("fpmc_top: timer width TW too small for a timing count");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges

  logic            cs_n_s;
  logic            sck_s;
  logic            si_s;
  logic            cs_q;
  logic            sck_q;

  fpmc_sync #(
    .W       (3),
    .RST_VAL (`FPMC_PIN_RST)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({cs_n, sck, si}),
    .q     ({cs_n_s, sck_s, si_s})
  );

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cs_q  <= 1'b1;
      sck_q <= 1'b0;
    end
    else
    begin
      cs_q  <= cs_n_s;
      sck_q <= sck_s;
    end
  end

  wire frame_start = !cs_n_s && cs_q;
  wire frame_end   = cs_n_s && !cs_q;
  wire bit_strobe  = !cs_n_s && sck_s && !sck_q;

  ////////////////////////////////////////////////////////////////////////////
  // frame decoder

  fpmc_state_t     state;
  fpmc_state_t     next_state;
  logic [6:0]      shift;
  logic [2:0]      bit_cnt;
  logic [2:0]      byte_cnt;
  logic [7:0]      op0;
  logic            cfg_ok;
  logic            cfg_sel;
  logic            frame_live;

  wire [7:0] new_byte  = {shift, si_s};
  wire       byte_done = bit_strobe && (bit_cnt == 3'h7);
  wire       cfg_byte_ok =
    (byte_cnt == 3'h0) ? (new_byte == `FPMC_CFG_B0) :
    (byte_cnt == 3'h1) ? (cfg_ok && new_byte == `FPMC_CFG_B1) :
    (byte_cnt == 3'h2) ? (cfg_ok && new_byte == `FPMC_CFG_B2) :
    (byte_cnt == 3'h3) ? (cfg_ok && (new_byte == `FPMC_CFG_B3_256 ||
                                     new_byte == `FPMC_CFG_B3_264)) :
    1'b0;

  // frames are only heard in standby, config and deep power-down
  // a frame opened during the exit time stays dead to its end
  wire live_now = (state == PW_STANDBY) || (state == PW_CONFIG) ||
                  (state == PW_DEEP);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      frame_live <= 1'b0;
    else if (frame_start)
      frame_live <= live_now;
    else if (frame_end)
      frame_live <= 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      shift   <= 7'h00;
      bit_cnt <= 3'h0;
    end
    else if (frame_start)
    begin
      shift   <= 7'h00;
      bit_cnt <= 3'h0;
    end
    else if (bit_strobe)
    begin
      shift   <= new_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // byte count saturates past the longest sequence; later bytes are ignored
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      byte_cnt <= 3'h0;
      op0      <= 8'h00;
      cfg_ok   <= 1'b0;
      cfg_sel  <= 1'b0;
    end
    else if (frame_start)
      byte_cnt <= 3'h0;
    else if (byte_done && byte_cnt != 3'h7)
    begin
      byte_cnt <= byte_cnt + 3'h1;
      cfg_ok   <= cfg_byte_ok;
      if (byte_cnt == 3'h0)
        op0 <= new_byte;
      if (byte_cnt == 3'h3)
        cfg_sel <= !new_byte[0];
    end
  end

  // a power-down opcode counts only once its last bit is in
  wire first_in   = frame_live && (byte_cnt != 3'h0);
  wire cmd_deep   = first_in && (op0 == `FPMC_OP_DEEP);
  wire cmd_resume = first_in && (op0 == `FPMC_OP_RESUME);
  wire cmd_ultra  = first_in && (op0 == `FPMC_OP_ULTRA);
  // exact four bytes, deselect right after the last bit
  wire cmd_cfg    = frame_live && cfg_ok && (byte_cnt == `FPMC_CFG_LEN) &&
                    (bit_cnt == 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // power-mode state machine

  logic [TW-1:0]   timer;
  logic [TW-1:0]   next_timer;
  logic            cfg_target;

  wire timer_done = (timer == TW'(1));

  always_comb
  begin
    next_state = state;
    next_timer = (timer != '0) ? timer - TW'(1) : timer;
    case (state)
      PW_STANDBY:
        // a busy array drops power-down requests
        if (frame_end && !array_busy)
        begin
          if (cmd_deep)
          begin
            next_state = PW_DEEP_ENTER;
            next_timer = TW'(DEEP_ENTRY_CYC);
          end
          else if (cmd_ultra)
          begin
            next_state = PW_ULTRA_ENTER;
            next_timer = TW'(ULTRA_ENTRY_CYC);
          end
          else if (cmd_cfg)
          begin
            next_state = PW_CONFIG;
            next_timer = TW'(CONFIG_CYC);
          end
        end
      // power-down requests fall through while configuring
      PW_CONFIG:
        if (timer_done)
          next_state = PW_STANDBY;
      PW_DEEP_ENTER:
        if (timer_done)
          next_state = PW_DEEP;
      // only resume is heard; partial resume stays here
      PW_DEEP:
        if (frame_end && cmd_resume)
        begin
          next_state = PW_DEEP_RESUME;
          next_timer = TW'(DEEP_RESUME_CYC);
        end
      // back to standby after the resume time
      PW_DEEP_RESUME:
        if (timer_done)
          next_state = PW_STANDBY;
      PW_ULTRA_ENTER:
        if (timer_done)
          next_state = PW_ULTRA;
      // any pulse wakes, whatever was shifted during it
      PW_ULTRA:
        if (frame_end)
        begin
          next_state = PW_ULTRA_EXIT;
          next_timer = TW'(ULTRA_EXIT_CYC);
        end
      PW_ULTRA_EXIT:
        if (timer_done)
          next_state = PW_STANDBY;
      default:
        next_state = PW_STANDBY;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= PW_STANDBY;
      timer <= '0;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page size, nonvolatile copy

  logic            nv_loaded;
  wire cfg_start = (state == PW_STANDBY) && (next_state == PW_CONFIG);
  wire cfg_end   = (state == PW_CONFIG) && timer_done;

  // shipped value until the stored cell is read after reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      nv_loaded  <= 1'b0;
      page_256   <= `FPMC_PAGE256_RST;
      cfg_target <= `FPMC_PAGE256_RST;
    end
    else
    begin
      nv_loaded <= 1'b1;
      if (!nv_loaded)
        page_256 <= nv_page_256;
      // new size takes effect at end of program cycle
      else if (cfg_end)
        page_256 <= cfg_target;
      if (cfg_start)
        cfg_target <= cfg_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fail flag and status

  // an abort reads as no failure
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      program_fail_flag <= 1'b0;
    else if (op_done)
      program_fail_flag <= op_fail && !op_abort;
  end

  wire ready_w = !array_busy && (state != PW_CONFIG);

  wire [7:0] status1_w;
  wire [7:0] status2_w;
  assign status1_w = {ready_w, compare_result, DENSITY_CODE, protect_on, page_256};
  assign status2_w = {ready_w, 1'b0, program_fail_flag, 5'h00};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      standby        <= 1'b0;
      deep_sleep     <= 1'b0;
      ultra_sleep    <= 1'b0;
      ready          <= 1'b0;
      cmd_enable     <= 1'b0;
      status_enable  <= 1'b0;
      buffer_lost    <= 1'b0;
      nv_store       <= 1'b0;
      nv_store_value <= `FPMC_PAGE256_RST;
      status_byte1   <= 8'h00;
      status_byte2   <= 8'h00;
    end
    else
    begin
      standby        <= (state == PW_STANDBY) && cs_n_s && !array_busy;
      deep_sleep     <= (state == PW_DEEP);
      ultra_sleep    <= (state == PW_ULTRA);
      ready          <= ready_w;
      cmd_enable     <= (state == PW_STANDBY);
      status_enable  <= (state == PW_STANDBY) || (state == PW_CONFIG);
      // buffer content dropped on ultra-deep entry
      buffer_lost    <= (state == PW_STANDBY) && (next_state == PW_ULTRA_ENTER);
      nv_store       <= cfg_end;
      nv_store_value <= cfg_end ? cfg_target : nv_store_value;
      status_byte1   <= status1_w;
      status_byte2   <= status2_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int DEEP_BOUND   = DEEP_ENTRY_CYC + 2;
  localparam int RESUME_BOUND = DEEP_RESUME_CYC + 2;
  localparam int ULTRA_BOUND  = ULTRA_ENTRY_CYC + 2;

  fail_set_a: assert property (
    @(posedge clk) disable iff (reset)
    op_done && op_fail && !op_abort |=> program_fail_flag)
    else $error("fail flag not set after failed operation");

  abort_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    op_done && op_abort |=> !program_fail_flag)
    else $error("fail flag set by aborted operation");

  standby_out_a: assert property (
    @(posedge clk) disable iff (reset)
    state == PW_STANDBY && cs_n_s && !array_busy |=> standby)
    else $error("standby not shown while idle");

  deep_hold_a: assert property (
    @(posedge clk) disable iff (reset)
    state == PW_DEEP && !(frame_end && cmd_resume) |=> state == PW_DEEP)
    else $error("deep power-down left without resume");

  deep_entry_a: assert property (
    @(posedge clk) disable iff (reset)
    $rose(state == PW_DEEP_ENTER) |-> ##[1:DEEP_BOUND] deep_sleep)
    else $error("deep power-down not reached in time");

  short_abort_a: assert property (
    @(posedge clk) disable iff (reset)
    state == PW_STANDBY && frame_end && byte_cnt == 3'h0 |=> state == PW_STANDBY)
    else $error("partial opcode left standby");

  busy_ignore_a: assert property (
    @(posedge clk) disable iff (reset)
    state == PW_STANDBY && frame_end && array_busy |=>
      state != PW_DEEP_ENTER && state != PW_ULTRA_ENTER)
    else $error("power-down taken while busy");

  resume_time_a: assert property (
    @(posedge clk) disable iff (reset)
    $rose(state == PW_DEEP_RESUME) |-> ##[1:RESUME_BOUND] state == PW_STANDBY)
    else $error("resume did not reach standby in time");

  ultra_entry_a: assert property (
    @(posedge clk) disable iff (reset)
    $rose(state == PW_ULTRA_ENTER) |-> ##[1:ULTRA_BOUND] ultra_sleep)
    else $error("ultra-deep not reached in time");

  exit_ignore_a: assert property (
    @(posedge clk) disable iff (reset)
    state == PW_ULTRA_EXIT && frame_start |=> !frame_live)
    else $error("frame heard during ultra-deep exit");

  cfg_busy_a: assert property (
    @(posedge clk) disable iff (reset)
    state == PW_CONFIG |=> !ready)
    else $error("ready shown during config cycle");

endmodule // fpmc_top

// ### fpmc_host.sv
/*
  Behavioural serial host driving chip select, serial clock and data in.
  Assumes mode 0 framing and a system clock to align frame starts.
*/
`timescale 1ns/10ps

module fpmc_host #(
  parameter real WAKE_PULSE_NS = 400.0,
  parameter real HALF_NS       = 62.5
) (
  // system clock for frame alignment
  input  wire logic clk,
  // serial link pins
  output logic      cs_n,
  output logic      sck,
  output logic      si
);

  initial
  begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // data left aligned, msb first; nbits of 0 gives a bare wake pulse
  // frame then deselect
  task automatic frame(input logic [31:0] data, input int nbits);
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    if (nbits == 0)
      #(WAKE_PULSE_NS);
    for (int i = 0; i < nbits; i++)
    begin
      si = data[31-i];
      #(HALF_NS) sck = 1'b1;
      #(HALF_NS) sck = 1'b0;
    end
    #(HALF_NS) cs_n = 1'b1;
    // released line: no pull, so never leave the last value
    si = ~si;
    repeat (6) @(posedge clk);
    #1;
  endtask

endmodule // fpmc_host

// ### fpmc_top_tb_top.sv
/*
  Self-checking bench of the power-mode and page-size block.
  Assumes the serial host model and shortened timing counts.
*/
`timescale 1ns/10ps

module fpmc_top_tb_top
  import fpmc_pkg::*;
;
  logic       clk, reset, array_busy, op_done, op_fail, op_abort;
  logic       compare_result, protect_on, nv_page_256;
  logic       cs_n, sck, si, nv_store, nv_store_value, standby, deep_sleep;
  logic       ultra_sleep, ready, cmd_enable, status_enable, buffer_lost;
  logic       program_fail_flag, page_256;
  logic [7:0] status_byte1, status_byte2;
  int         miscompares, n_compared, cycles, n_store, n_lost;
  logic       store_val;

  fpmc_top #(.DEEP_ENTRY_CYC(8), .DEEP_RESUME_CYC(10), .ULTRA_ENTRY_CYC(8),
             .ULTRA_EXIT_CYC(20), .CONFIG_CYC(200)) uut (
    .clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si),
    .array_busy(array_busy), .op_done(op_done), .op_fail(op_fail),
    .op_abort(op_abort), .compare_result(compare_result), .protect_on(protect_on),
    .nv_page_256(nv_page_256), .nv_store(nv_store), .nv_store_value(nv_store_value),
    .standby(standby), .deep_sleep(deep_sleep), .ultra_sleep(ultra_sleep),
    .ready(ready), .cmd_enable(cmd_enable), .status_enable(status_enable),
    .buffer_lost(buffer_lost), .program_fail_flag(program_fail_flag),
    .page_256(page_256), .status_byte1(status_byte1), .status_byte2(status_byte2));

  fpmc_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    if (nv_store === 1'b1)
    begin
      n_store++;
      store_val = nv_store_value;
    end
    if (buffer_lost === 1'b1)
      n_lost++;
    if (cycles == 30000)
    begin
      miscompares++;
      $display("timeout after %0d cycles", cycles);
      finish_test();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expv);
    n_compared++;
    if (seen !== expv)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, expv, seen);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0:       return standby;
      1:       return deep_sleep;
      2:       return ultra_sleep;
      default: return ready;
    endcase
  endfunction

  // bounded wait, then one compare that also flags a late change
  task automatic wait_sig(input int sel, input logic v, input int bound, input string name);
    for (int k = 0; k < bound; k++)
    begin
      if (pick(sel) === v)
        break;
      @(posedge clk);
      #1;
    end
    check(name, {7'h0, pick(sel)}, {7'h0, v});
  endtask

  task automatic op(input logic f, input logic a);
    @(posedge clk);
    #1;
    op_done  = 1'b1;
    op_fail  = f;
    op_abort = a;
    @(posedge clk);
    #1;
    {op_done, op_fail, op_abort} = 3'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic finish_test();
    $display("miscompares %0d n_compared %0d", miscompares, n_compared);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {array_busy, op_done, op_fail, op_abort, protect_on} = 5'h00;
    compare_result = 1'b1;
    nv_page_256    = 1'b1;
    reset          = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    settle(4);
    check("standby", {7'h0, standby}, 8'h01);
    check("page_256", {7'h0, page_256}, 8'h01);
    check("status1", status_byte1, 8'hE9);
    check("status2", status_byte2, 8'h80);
    op(1'b1, 1'b0);
    check("status2", status_byte2, 8'hA0);
    op(1'b0, 1'b1);
    check("fail", {7'h0, program_fail_flag}, 8'h00);
    op(1'b1, 1'b0);
    op(1'b0, 1'b0);
    check("fail", {7'h0, program_fail_flag}, 8'h00);
    host.frame({8'hB9, 24'h0}, 7);
    settle(20);
    check("deep", {7'h0, deep_sleep}, 8'h00);
    host.frame({8'hB9, 8'h5A, 16'h0}, 16);
    wait_sig(1, 1'b1, 30, "deep");
    check("cmd_en", {7'h0, cmd_enable}, 8'h00);
    check("stat_en", {7'h0, status_enable}, 8'h00);
    host.frame({8'h79, 24'h0}, 8);
    settle(30);
    check("ultra", {7'h0, ultra_sleep}, 8'h00);
    host.frame({8'hAB, 24'h0}, 7);
    settle(30);
    check("deep", {7'h0, deep_sleep}, 8'h01);
    host.frame({8'hAB, 8'hFF, 16'h0}, 16);
    wait_sig(0, 1'b1, 40, "standby");
    host.frame({8'h79, 8'h33, 16'h0}, 16);
    wait_sig(2, 1'b1, 30, "ultra");
    check("lost", n_lost[7:0], 8'h01);
    check("cmd_en", {7'h0, cmd_enable}, 8'h00);
    check("stat_en", {7'h0, status_enable}, 8'h00);
    host.frame({8'hAB, 24'h0}, 8);
    host.frame({8'hB9, 24'h0}, 8);
    wait_sig(0, 1'b1, 40, "standby");
    check("deep", {7'h0, deep_sleep}, 8'h00);
    host.frame({8'h79, 24'h0}, 8);
    wait_sig(2, 1'b1, 30, "ultra");
    host.frame(32'h0, 0);
    wait_sig(0, 1'b1, 40, "standby");
    array_busy = 1'b1;
    host.frame({8'hB9, 24'h0}, 8);
    settle(30);
    check("deep", {7'h0, deep_sleep}, 8'h00);
    check("ready", {7'h0, ready}, 8'h00);
    check("standby", {7'h0, standby}, 8'h00);
    host.frame({8'h79, 24'h0}, 8);
    settle(30);
    check("ultra", {7'h0, ultra_sleep}, 8'h00);
    array_busy = 1'b0;
    host.frame({8'hB9, 24'h0}, 8);
    wait_sig(1, 1'b1, 30, "deep");
    host.frame({8'hAB, 24'h0}, 8);
    wait_sig(0, 1'b1, 40, "standby");
    // two page-size changes only, far inside the endurance limit
    host.frame(32'h3D2A80A7, 32);
    check("status1", status_byte1, 8'h69);
    check("status2", status_byte2, 8'h00);
    check("stat_en", {7'h0, status_enable}, 8'h01);
    wait_sig(3, 1'b1, 250, "ready");
    check("page_256", {7'h0, page_256}, 8'h00);
    check("status1", status_byte1, 8'hE8);
    check("stores", n_store[7:0], 8'h01);
    check("store_val", {7'h0, store_val}, 8'h00);
    // power cycle: the cell hands back what was stored
    nv_page_256 = store_val;
    reset       = 1'b1;
    settle(2);
    reset       = 1'b0;
    settle(4);
    check("page_256", {7'h0, page_256}, 8'h00);
    check("standby", {7'h0, standby}, 8'h01);
    host.frame(32'h3D2A80A6, 32);
    check("ready", {7'h0, ready}, 8'h00);
    // whole deep request lands inside the config cycle
    host.frame({8'hB9, 24'h0}, 8);
    wait_sig(3, 1'b1, 250, "ready");
    check("deep", {7'h0, deep_sleep}, 8'h00);
    check("page_256", {7'h0, page_256}, 8'h01);
    check("store_val", {7'h0, store_val}, 8'h01);
    finish_test();
  end

endmodule // fpmc_top_tb_top
